// ---- pkg/ddc_params.svh ----
/*
 * Constants of the drive device-control block: object indexes, reset values,
 * field positions, state encodings, mode codes and stop selector values.
 * Assumes inclusion by bare name from the control module; the package and the decoder do not include it.
 */
`ifndef DDC_PARAMS_SVH
`define DDC_PARAMS_SVH

// Object indexes of the device-control objects
`define DDC_IDX_CMD 16'h6040
`define DDC_IDX_STAT 16'h6041
`define DDC_IDX_QSTOP 16'h605A
`define DDC_IDX_SHDN 16'h605B
`define DDC_IDX_DISOP 16'h605C
`define DDC_IDX_HALT 16'h605D
`define DDC_IDX_FRCT 16'h605E

// Reset values of the writable objects
`define DDC_RST_CMD 16'h0000
`define DDC_RST_QSTOP 16'h0002
`define DDC_RST_SHDN 16'h0000
`define DDC_RST_DISOP 16'h0000
`define DDC_RST_HALT 16'h0000
`define DDC_RST_FRCT 16'h0000

// Command word bit positions
`define DDC_CW_SWON 0
`define DDC_CW_EVOLT 1
`define DDC_CW_QSTOP 2
`define DDC_CW_ENOP 3
`define DDC_CW_MODE0 4
`define DDC_CW_MODE1 5
`define DDC_CW_MODE2 6
`define DDC_CW_FRST 7
`define DDC_CW_HALT 8

// Status word bit positions
`define DDC_SW_VOLT 4
`define DDC_SW_WARN 7
`define DDC_SW_REMOTE 9
`define DDC_SW_TGT 10
`define DDC_SW_LIMIT 11
`define DDC_SW_MODE0 12
`define DDC_SW_MODE1 13

// State encodings as {bit6, bit5, bits3..0}
`define DDC_ENC_NRDY 6'h00
`define DDC_ENC_SOD 6'h20
`define DDC_ENC_RDY 6'h11
`define DDC_ENC_SWON 6'h13
`define DDC_ENC_OPEN 6'h17
`define DDC_ENC_QSA 6'h07
`define DDC_ENC_FRA 6'h0F
`define DDC_ENC_FLT 6'h08

// Operating mode codes
`define DDC_MODE_PP 8'h01
`define DDC_MODE_PV 8'h03
`define DDC_MODE_HM 8'h06

// Stop selector values
`define DDC_OPT_OFF 16'h0000
`define DDC_OPT_DECEL 16'h0001
`define DDC_OPT_URGENT 16'h0002
`define DDC_OPT_HOLD 16'h0005
`define DDC_OPT_HOLD_URG 16'h0006

`endif

// ---- pkg/ddc_pkg.sv ----
/*
 * Types of the drive device-control block: state and decoded command.
 * Assumes ddc_params.svh holds all numeric constants.
 */
package ddc_pkg;

	// Device-control states
	typedef enum logic [2:0] {
		ST_NRDY,
		ST_SOD,
		ST_RDY,
		ST_SWON,
		ST_OPEN,
		ST_QSA,
		ST_FRA,
		ST_FLT
	} ddc_state_t;

	// Decoded state-machine commands
	typedef enum logic [2:0] {
		CMD_SHDN,
		CMD_SWON,
		CMD_DISV,
		CMD_QSTP,
		CMD_ENOP,
		CMD_FRST
	} ddc_cmd_t;

endpackage : ddc_pkg

// ---- core/ddc_cmd_decode.sv ----
/*
 * Decoder of the five state-machine bits of the command word.
 * Assumes bits arrive as {fault reset, enable op, quick stop, enable voltage, switch on}.
 */
`timescale 1ns/1ps
module ddc_cmd_decode (
	input wire logic [4:0] cmd_bits_i, // Five command bits
	output ddc_pkg::ddc_cmd_t cmd_o // Decoded command
);

	// [R1] five-bit decode
	// Priority chain: fault reset, then voltage, quick stop, switch on
	always_comb begin
		if (cmd_bits_i[4]) begin
			// [R8] fault reset wins
			cmd_o = ddc_pkg::CMD_FRST;
		end else if (!cmd_bits_i[1]) begin
			// [R4] disable voltage
			cmd_o = ddc_pkg::CMD_DISV;
		end else if (!cmd_bits_i[2]) begin
			// [R5] quick stop
			cmd_o = ddc_pkg::CMD_QSTP;
		end else if (!cmd_bits_i[0]) begin
			// [R2] shutdown decode
			cmd_o = ddc_pkg::CMD_SHDN;
		end else if (cmd_bits_i[3]) begin
			// [R7] enable operation
			cmd_o = ddc_pkg::CMD_ENOP;
		end else begin
			// [R3] switch on, also disable operation
			cmd_o = ddc_pkg::CMD_SWON;
		end
	end

endmodule : ddc_cmd_decode

// ---- core/ddc_ctrl.sv ----
/*
 * Drive device-control block: command word, state machine, status word
 * and stop selector objects, reached by object index.
 * Assumes inputs synchronous to clk_sys_i and mode_i holding the active mode.
 */
`timescale 1ns/1ps
`include "ddc_params.svh"
// Operation
// [R1] Command bits 0-3 and 7 form one five-bit command; don't-cares ignored.
// [R2] x110 without fault reset is shutdown: transitions 2, 6, 8.
// [R3] 0111 or 1111 without fault reset is switch on: transition 3.
// [R4] Enable-voltage low is disable voltage: transitions 7, 9, 10, 12.
// [R5] Quick-stop low, enable-voltage high is quick stop: transitions 7, 10, 11.
// [R6] 0111 is disable operation: transition 5.
// [R7] 1111 is enable operation: transitions 4 and 16.
// [R8] Fault-reset bit set is fault reset: transition 15.
// [R9] Bits 4-6 are mode specific; bit 8 is halt in every mode.
// [R10] Status encodes not ready, switch-on disabled, ready, switched on.
// [R11] Status encodes operation enabled, quick stop, fault reaction, fault.
// [R12] Status bit 4 follows main motor power.
// [R13] Status bit 5 low means stopping per quick-stop selector.
// [R14] Status bit 7 set while an alarm is detected.
// [R15] Status bit 9 set while the command word is being handled.
// [R16] Position mode bit 10: target reached or halted to zero; new target clears.
// [R17] Velocity mode bit 10: target speed reached or halted to zero.
// [R18] Bit 11 set on torque limit or forward/reverse limit position.
// [R19] Bits 12-13 carry mode-specific acknowledge and error flags.
// [R20] Shutdown from operation: excitation off now (0) or after stop (1).
// [R21] Disable operation: excitation off now (0) or after stop (1).
// [R22] After self-initialisation the machine enters switch-on disabled.
// [R23] An alarm forces any state into the fault path.
// [R24] Operation enabled is reached only through transitions 2, 3, 4; the code also enters it from quick stop active (16).
// [R25] Commands invalid in the current state are ignored.
// [R26] Reserved command bits ignored; reserved status bits read zero.
module ddc_ctrl (
	input wire logic clk_sys_i, // System clock, 20 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire logic obj_wr_i, // Object write strobe
	input wire logic obj_rd_i, // Object read strobe
	input wire logic [15:0] obj_idx_i, // Object index
	input wire logic [15:0] obj_wdata_i, // Object write data
	input wire logic [7:0] mode_i, // Active operating mode code
	input wire logic init_done_i, // Self-initialisation complete
	input wire logic alarm_i, // Alarm condition present
	input wire logic main_power_on_i, // Main motor power applied
	input wire logic motor_stopped_i, // Motor at standstill
	input wire logic pos_reached_i, // Position inside target window
	input wire logic vel_reached_i, // Speed at target speed
	input wire logic home_done_i, // Home position reached
	input wire logic torque_lim_i, // Torque above its limit
	input wire logic fwd_lim_i, // Forward limit position reached
	input wire logic rev_lim_i, // Reverse limit position reached
	input wire logic set_ack_i, // Set-point acknowledge
	input wire logic follow_err_i, // Following error
	input wire logic speed_flag_i, // Speed flag
	input wire logic slip_err_i, // Maximum slippage error
	input wire logic home_ok_i, // Homing attained
	input wire logic home_err_i, // Homing error
	output logic [15:0] obj_rdata_o, // Object read data
	output logic obj_ack_o, // Access answered, one cycle
	output logic obj_err_o, // Access refused, with ack
	output logic [15:0] status_o, // Status word
	output logic excite_o, // Motor excitation on
	output logic main_power_o, // Main power requested
	output logic decel_o, // Decelerate to standstill
	output logic decel_urgent_o, // Deceleration is urgent
	output logic new_setpoint_o, // Position: new target strobe
	output logic change_imm_o, // Position: apply immediately
	output logic abs_rel_o, // Position: relative target
	output logic homing_start_o, // Homing: start
	output logic halt_o, // Pause request
	output logic halt_urgent_o // Pause decelerates urgently
);

	logic [15:0] cw_r;
	logic [15:0] opt_qs_r;
	logic [15:0] opt_sd_r;
	logic [15:0] opt_do_r;
	logic [15:0] opt_halt_r;
	logic [15:0] opt_fr_r;
	ddc_pkg::ddc_state_t state_r;
	ddc_pkg::ddc_state_t state_nxt;
	ddc_pkg::ddc_cmd_t cmd;
	logic decel_nxt;
	logic urgent_nxt;
	logic excite_nxt;
	logic qs_hold;
	logic cw4_q_r;
	logic tgt_pos_r;
	logic wr_ok;
	logic known_idx;
	logic [15:0] rdata_nxt;
	logic [15:0] status_nxt;
	logic [5:0] enc;
	logic mode_pp;
	logic mode_pv;
	logic mode_hm;

	// Mode selects
	assign mode_pp = (mode_i == `DDC_MODE_PP);
	assign mode_pv = (mode_i == `DDC_MODE_PV);
	assign mode_hm = (mode_i == `DDC_MODE_HM);
	assign qs_hold = (opt_qs_r == `DDC_OPT_HOLD) || (opt_qs_r == `DDC_OPT_HOLD_URG);

	// [R1] command decoder
	ddc_cmd_decode u_dec (
		.cmd_bits_i({cw_r[`DDC_CW_FRST], cw_r[`DDC_CW_ENOP], cw_r[`DDC_CW_QSTOP],
			cw_r[`DDC_CW_EVOLT], cw_r[`DDC_CW_SWON]}),
		.cmd_o(cmd)
	);

	// Index decode and value check for writes
	always_comb begin
		known_idx = 1'b1;
		wr_ok = 1'b0;
		rdata_nxt = 16'h0000;
		if (obj_idx_i == `DDC_IDX_CMD) begin
			wr_ok = 1'b1;
			rdata_nxt = cw_r;
		end else if (obj_idx_i == `DDC_IDX_STAT) begin
			rdata_nxt = status_o;
		end else if (obj_idx_i == `DDC_IDX_QSTOP) begin
			wr_ok = (obj_wdata_i == `DDC_OPT_OFF) || (obj_wdata_i == `DDC_OPT_DECEL) ||
				(obj_wdata_i == `DDC_OPT_URGENT) || (obj_wdata_i == `DDC_OPT_HOLD) ||
				(obj_wdata_i == `DDC_OPT_HOLD_URG);
			rdata_nxt = opt_qs_r;
		end else if (obj_idx_i == `DDC_IDX_SHDN) begin
			wr_ok = (obj_wdata_i == `DDC_OPT_OFF) || (obj_wdata_i == `DDC_OPT_DECEL);
			rdata_nxt = opt_sd_r;
		end else if (obj_idx_i == `DDC_IDX_DISOP) begin
			wr_ok = (obj_wdata_i == `DDC_OPT_OFF) || (obj_wdata_i == `DDC_OPT_DECEL);
			rdata_nxt = opt_do_r;
		end else if (obj_idx_i == `DDC_IDX_HALT) begin
			wr_ok = (obj_wdata_i == `DDC_OPT_DECEL) || (obj_wdata_i == `DDC_OPT_URGENT);
			rdata_nxt = opt_halt_r;
		end else if (obj_idx_i == `DDC_IDX_FRCT) begin
			wr_ok = (obj_wdata_i == `DDC_OPT_OFF);
			rdata_nxt = opt_fr_r;
		end else begin
			known_idx = 1'b0;
		end
	end

	// Access answer, one cycle after the strobe
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			obj_ack_o <= 1'b0;
			obj_err_o <= 1'b0;
			obj_rdata_o <= 16'h0000;
		end else begin
			obj_ack_o <= obj_wr_i || obj_rd_i;
			obj_err_o <= (obj_wr_i && !wr_ok) || (obj_rd_i && !obj_wr_i && !known_idx);
			obj_rdata_o <= (obj_rd_i && !obj_wr_i) ? rdata_nxt : 16'h0000;
		end
	end

	// Writable objects; [R26] reserved command bits stored but unused
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cw_r <= `DDC_RST_CMD;
			opt_qs_r <= `DDC_RST_QSTOP;
			opt_sd_r <= `DDC_RST_SHDN;
			opt_do_r <= `DDC_RST_DISOP;
			opt_halt_r <= `DDC_RST_HALT;
			opt_fr_r <= `DDC_RST_FRCT;
		end else if (obj_wr_i && wr_ok) begin
			if (obj_idx_i == `DDC_IDX_CMD) begin
				cw_r <= obj_wdata_i;
			end else if (obj_idx_i == `DDC_IDX_QSTOP) begin
				opt_qs_r <= obj_wdata_i;
			end else if (obj_idx_i == `DDC_IDX_SHDN) begin
				opt_sd_r <= obj_wdata_i;
			end else if (obj_idx_i == `DDC_IDX_DISOP) begin
				opt_do_r <= obj_wdata_i;
			end else if (obj_idx_i == `DDC_IDX_HALT) begin
				opt_halt_r <= obj_wdata_i;
			end else begin
				opt_fr_r <= obj_wdata_i;
			end
		end
	end

	// State transitions; [R25] unmatched commands keep the state
	always_comb begin
		state_nxt = state_r;
		decel_nxt = 1'b0;
		urgent_nxt = 1'b0;
		// [R23] alarm forces fault path
		if (alarm_i && state_r != ddc_pkg::ST_FRA && state_r != ddc_pkg::ST_FLT) begin
			state_nxt = ddc_pkg::ST_FRA;
		end else begin
			case (state_r)
				// [R22] wait for self-initialisation
				ddc_pkg::ST_NRDY: begin
					if (init_done_i) state_nxt = ddc_pkg::ST_SOD;
				end
				// [R24] only shutdown or an alarm leaves here
				ddc_pkg::ST_SOD: begin
					if (cmd == ddc_pkg::CMD_SHDN) state_nxt = ddc_pkg::ST_RDY;
				end
				// [R3] switch on, either enable-op value
				ddc_pkg::ST_RDY: begin
					if (cmd == ddc_pkg::CMD_SWON || cmd == ddc_pkg::CMD_ENOP) begin
						state_nxt = ddc_pkg::ST_SWON;
					end else if (cmd == ddc_pkg::CMD_DISV || cmd == ddc_pkg::CMD_QSTP) begin
						state_nxt = ddc_pkg::ST_SOD;
					end
				end
				// [R7] enable operation
				ddc_pkg::ST_SWON: begin
					if (cmd == ddc_pkg::CMD_ENOP) begin
						state_nxt = ddc_pkg::ST_OPEN;
					end else if (cmd == ddc_pkg::CMD_SHDN) begin
						state_nxt = ddc_pkg::ST_RDY;
					end else if (cmd == ddc_pkg::CMD_DISV || cmd == ddc_pkg::CMD_QSTP) begin
						state_nxt = ddc_pkg::ST_SOD;
					end
				end
				ddc_pkg::ST_OPEN: begin
					if (cmd == ddc_pkg::CMD_SWON) begin
						// [R6] [R21] disable operation
						if (opt_do_r == `DDC_OPT_DECEL && !motor_stopped_i) decel_nxt = 1'b1;
						else state_nxt = ddc_pkg::ST_SWON;
					end else if (cmd == ddc_pkg::CMD_SHDN) begin
						// [R20] shutdown stop choice
						if (opt_sd_r == `DDC_OPT_DECEL && !motor_stopped_i) decel_nxt = 1'b1;
						else state_nxt = ddc_pkg::ST_RDY;
					end else if (cmd == ddc_pkg::CMD_DISV) begin
						state_nxt = ddc_pkg::ST_SOD;
					end else if (cmd == ddc_pkg::CMD_QSTP) begin
						state_nxt = ddc_pkg::ST_QSA;
					end
				end
				// [R13] stop per quick-stop selector
				ddc_pkg::ST_QSA: begin
					if (cmd == ddc_pkg::CMD_DISV) begin
						state_nxt = ddc_pkg::ST_SOD;
					end else if (qs_hold && cmd == ddc_pkg::CMD_ENOP) begin
						state_nxt = ddc_pkg::ST_OPEN;
					end else if (opt_qs_r == `DDC_OPT_OFF) begin
						state_nxt = ddc_pkg::ST_SOD;
					end else if (!motor_stopped_i) begin
						decel_nxt = 1'b1;
						urgent_nxt = (opt_qs_r == `DDC_OPT_URGENT) ||
							(opt_qs_r == `DDC_OPT_HOLD_URG);
					end else if (!qs_hold) begin
						state_nxt = ddc_pkg::ST_SOD;
					end
				end
				// Fault reaction drops excitation at once
				ddc_pkg::ST_FRA: begin
					state_nxt = ddc_pkg::ST_FLT;
				end
				// [R8] fault reset once alarm gone
				ddc_pkg::ST_FLT: begin
					if (cmd == ddc_pkg::CMD_FRST && !alarm_i) state_nxt = ddc_pkg::ST_SOD;
				end
			endcase
		end
	end

	// Excitation held in operation and while quick stop decelerates or holds
	always_comb begin
		excite_nxt = (state_nxt == ddc_pkg::ST_OPEN) ||
			(state_nxt == ddc_pkg::ST_QSA && (decel_nxt || qs_hold));
	end

	// State and drive outputs
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_r <= ddc_pkg::ST_NRDY;
			excite_o <= 1'b0;
			main_power_o <= 1'b0;
			decel_o <= 1'b0;
			decel_urgent_o <= 1'b0;
		end else begin
			state_r <= state_nxt;
			excite_o <= excite_nxt;
			main_power_o <= (state_nxt == ddc_pkg::ST_SWON) || (state_nxt == ddc_pkg::ST_OPEN) ||
				(state_nxt == ddc_pkg::ST_QSA) || (state_nxt == ddc_pkg::ST_FRA);
			decel_o <= decel_nxt;
			decel_urgent_o <= urgent_nxt;
		end
	end

	// [R9] mode-specific command bits
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			new_setpoint_o <= 1'b0;
			change_imm_o <= 1'b0;
			abs_rel_o <= 1'b0;
			homing_start_o <= 1'b0;
			halt_o <= 1'b0;
			halt_urgent_o <= 1'b0;
		end else begin
			new_setpoint_o <= mode_pp && cw_r[`DDC_CW_MODE0];
			change_imm_o <= mode_pp && cw_r[`DDC_CW_MODE1];
			abs_rel_o <= mode_pp && cw_r[`DDC_CW_MODE2];
			homing_start_o <= mode_hm && cw_r[`DDC_CW_MODE0];
			halt_o <= cw_r[`DDC_CW_HALT];
			halt_urgent_o <= cw_r[`DDC_CW_HALT] && (opt_halt_r == `DDC_OPT_URGENT);
		end
	end

	// [R16] position target flag, set wins over new-target clear
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			cw4_q_r <= 1'b0;
			tgt_pos_r <= 1'b0;
		end else begin
			cw4_q_r <= cw_r[`DDC_CW_MODE0];
			if (pos_reached_i || (cw_r[`DDC_CW_HALT] && motor_stopped_i)) tgt_pos_r <= 1'b1;
			else if (cw_r[`DDC_CW_MODE0] && !cw4_q_r) tgt_pos_r <= 1'b0;
		end
	end

	// [R10] [R11] state encoding
	always_comb begin
		case (state_r)
			ddc_pkg::ST_NRDY: enc = `DDC_ENC_NRDY;
			ddc_pkg::ST_SOD: enc = `DDC_ENC_SOD;
			ddc_pkg::ST_RDY: enc = `DDC_ENC_RDY;
			ddc_pkg::ST_SWON: enc = `DDC_ENC_SWON;
			ddc_pkg::ST_OPEN: enc = `DDC_ENC_OPEN;
			ddc_pkg::ST_QSA: enc = `DDC_ENC_QSA;
			ddc_pkg::ST_FRA: enc = `DDC_ENC_FRA;
			ddc_pkg::ST_FLT: enc = `DDC_ENC_FLT;
		endcase
	end

	// Status word assembly; [R26] reserved bits stay zero
	always_comb begin
		status_nxt = 16'h0000;
		status_nxt[6:5] = enc[5:4];
		status_nxt[3:0] = enc[3:0];
		// [R12] voltage enabled
		status_nxt[`DDC_SW_VOLT] = main_power_on_i;
		// [R14] warning on alarm
		status_nxt[`DDC_SW_WARN] = alarm_i;
		// [R15] command handling active
		status_nxt[`DDC_SW_REMOTE] = (state_r != ddc_pkg::ST_NRDY);
		// [R18] internal limit
		status_nxt[`DDC_SW_LIMIT] = torque_lim_i || fwd_lim_i || rev_lim_i;
		// [R16] [R17] [R19] mode-specific flags
		if (mode_pp) begin
			status_nxt[`DDC_SW_TGT] = tgt_pos_r;
			status_nxt[`DDC_SW_MODE0] = set_ack_i;
			status_nxt[`DDC_SW_MODE1] = follow_err_i;
		end else if (mode_pv) begin
			status_nxt[`DDC_SW_TGT] = vel_reached_i || (cw_r[`DDC_CW_HALT] && motor_stopped_i);
			status_nxt[`DDC_SW_MODE0] = speed_flag_i;
			status_nxt[`DDC_SW_MODE1] = slip_err_i;
		end else if (mode_hm) begin
			status_nxt[`DDC_SW_TGT] = home_done_i || (cw_r[`DDC_CW_HALT] && motor_stopped_i);
			status_nxt[`DDC_SW_MODE0] = home_ok_i;
			status_nxt[`DDC_SW_MODE1] = home_err_i;
		end
	end

	// Status word register
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) status_o <= 16'h0000;
		else status_o <= status_nxt;
	end

	// Checks on the state machine and status word
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_reset_state: assert property ( // [R22]
		$fell(rst_i) |-> state_r == ddc_pkg::ST_NRDY)
		else $error("state not cleared by reset");

	a_init_entry: assert property ( // [R22]
		state_r == ddc_pkg::ST_NRDY && init_done_i && !alarm_i |=> state_r == ddc_pkg::ST_SOD)
		else $error("switch-on disabled not entered after init");

	a_alarm_fault: assert property ( // [R23]
		alarm_i && state_r != ddc_pkg::ST_FRA && state_r != ddc_pkg::ST_FLT
		|=> state_r == ddc_pkg::ST_FRA ##1 state_r == ddc_pkg::ST_FLT)
		else $error("alarm did not enter fault path");

	a_fault_reset: assert property ( // [R8]
		state_r == ddc_pkg::ST_FLT && cmd == ddc_pkg::CMD_FRST && !alarm_i
		|=> state_r == ddc_pkg::ST_SOD)
		else $error("fault reset ignored");

	a_shutdown_ready: assert property ( // [R2]
		state_r == ddc_pkg::ST_SOD && cmd == ddc_pkg::CMD_SHDN && !alarm_i
		|=> state_r == ddc_pkg::ST_RDY ##1 status_o[6:5] == 2'h1 && status_o[3:0] == 4'h1)
		else $error("shutdown did not reach ready");

	a_enter_open: assert property ( // [R24]
		state_r == ddc_pkg::ST_OPEN && $past(state_r) != ddc_pkg::ST_OPEN
		|-> $past(state_r) == ddc_pkg::ST_SWON || $past(state_r) == ddc_pkg::ST_QSA)
		else $error("operation enabled entered from wrong state");

	a_bad_cmd_held: assert property ( // [R25]
		state_r == ddc_pkg::ST_SOD && cmd == ddc_pkg::CMD_ENOP && !alarm_i
		|=> state_r == ddc_pkg::ST_SOD)
		else $error("invalid command changed state");

	a_open_status: assert property ( // [R11]
		state_r == ddc_pkg::ST_OPEN |=> status_o[6:5] == 2'h1 && status_o[3:0] == 4'h7)
		else $error("operation enabled encoded wrong");

	a_volt_warn: assert property ( // [R12]
		1'b1 |=> status_o[4] == $past(main_power_on_i) && status_o[7] == $past(alarm_i))
		else $error("voltage or warning bit wrong");

	a_reserved_zero: assert property ( // [R26]
		status_o[15:14] == 2'h0 && status_o[8] == 1'b0)
		else $error("reserved status bit set");

	a_shdn_decel: assert property ( // [R20]
		state_r == ddc_pkg::ST_OPEN && cmd == ddc_pkg::CMD_SHDN && !alarm_i &&
		opt_sd_r == `DDC_OPT_DECEL && !motor_stopped_i
		|=> state_r == ddc_pkg::ST_OPEN && decel_o && excite_o)
		else $error("shutdown did not decelerate first");

	a_disop_now: assert property ( // [R21]
		state_r == ddc_pkg::ST_OPEN && cmd == ddc_pkg::CMD_SWON && !alarm_i &&
		opt_do_r == `DDC_OPT_OFF |=> state_r == ddc_pkg::ST_SWON && !excite_o)
		else $error("disable operation kept excitation");

	a_qs_decel: assert property ( // [R13]
		state_r == ddc_pkg::ST_QSA && !alarm_i && cmd != ddc_pkg::CMD_DISV &&
		opt_qs_r != `DDC_OPT_OFF && !motor_stopped_i && !(qs_hold && cmd == ddc_pkg::CMD_ENOP)
		|=> decel_o && status_o[5] == 1'b0)
		else $error("quick stop did not decelerate");

	c_reach_open: cover property (state_r == ddc_pkg::ST_OPEN);
	c_reach_fault: cover property (state_r == ddc_pkg::ST_FLT);
	c_quick_stop: cover property (state_r == ddc_pkg::ST_QSA && decel_o);
	c_reenable: cover property (state_r == ddc_pkg::ST_QSA ##1 state_r == ddc_pkg::ST_OPEN);

endmodule : ddc_ctrl

// ---- test/ddc_master_model.sv ----
/*
 * Fieldbus master model: issues object reads and writes to the drive.
 * Assumes a one-cycle strobe answered by ack in the following cycle.
 */
`timescale 1ns/1ps
module ddc_master_model (
	input wire logic clk_sys_i, // System clock
	input wire logic ack_i, // Access answered
	input wire logic err_i, // Access refused
	input wire logic [15:0] rdata_i, // Read data
	output logic wr_o, // Write strobe
	output logic rd_o, // Read strobe
	output logic [15:0] idx_o, // Object index
	output logic [15:0] wdata_o // Write data
);
	// Idle port from time zero
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		idx_o = 16'h0000;
		wdata_o = 16'h0000;
	end
	// One access, answer taken at the edge after
	task automatic acc(input logic w, input logic [15:0] i, d,
		output logic [15:0] q, output logic a, e);
		@(posedge clk_sys_i);
		#1;
		wr_o = w;
		rd_o = !w;
		idx_o = i;
		wdata_o = d;
		@(posedge clk_sys_i);
		#1;
		q = rdata_i;
		a = ack_i;
		e = err_i;
		wr_o = 1'b0;
		rd_o = 1'b0;
		wdata_o = ~d; // Old data not left on the lines
	endtask : acc
endmodule : ddc_master_model

// ---- test/tb_top.sv ----
/*
 * Testbench of the drive device-control block: object access, state walk,
 * stop selectors, alarm path and status flags.
 * Assumes the master model drives the object port.
 */
`timescale 1ns/1ps
module tb_top;
	logic clk_sys_i, rst_i, obj_wr_i, obj_rd_i, obj_ack_o, obj_err_o, a, e;
	logic [15:0] obj_idx_i, obj_wdata_i, obj_rdata_o, status_o, q;
	logic [7:0] mode_i;
	logic init_done_i, alarm_i, main_power_on_i, motor_stopped_i, pos_reached_i, vel_reached_i;
	logic home_done_i, torque_lim_i, fwd_lim_i, rev_lim_i, set_ack_i, follow_err_i;
	logic speed_flag_i, slip_err_i, home_ok_i, home_err_i, excite_o, main_power_o, decel_o;
	logic decel_urgent_o, new_setpoint_o, change_imm_o, abs_rel_o, homing_start_o, halt_o;
	logic halt_urgent_o;
	logic [7:0] tm [4] = '{8'h03, 8'h03, 8'h01, 8'h06};
	logic [11:0] ts [4] = '{12'h022, 12'h300, 12'h0C8, 12'hC14};
	logic [15:0] te [4] = '{16'h0E40, 16'h3240, 16'h3A40, 16'h3E40};
	int miscompares, checked;

	ddc_master_model ddc_master_model_i (.clk_sys_i, .ack_i(obj_ack_o), .err_i(obj_err_o),
		.rdata_i(obj_rdata_o), .wr_o(obj_wr_i), .rd_o(obj_rd_i), .idx_o(obj_idx_i),
		.wdata_o(obj_wdata_i));
	ddc_ctrl ddc_ctrl_i (.clk_sys_i, .rst_i, .obj_wr_i, .obj_rd_i, .obj_idx_i, .obj_wdata_i,
		.mode_i, .init_done_i, .alarm_i, .main_power_on_i, .motor_stopped_i, .pos_reached_i,
		.vel_reached_i, .home_done_i, .torque_lim_i, .fwd_lim_i, .rev_lim_i, .set_ack_i,
		.follow_err_i, .speed_flag_i, .slip_err_i, .home_ok_i, .home_err_i, .obj_rdata_o,
		.obj_ack_o, .obj_err_o, .status_o, .excite_o, .main_power_o, .decel_o, .decel_urgent_o,
		.new_setpoint_o, .change_imm_o, .abs_rel_o, .homing_start_o, .halt_o, .halt_urgent_o);

	// Clock, 50 ns period
	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	// Compare one value
	task automatic chk(input logic [15:0] got, exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk

	// Object write, expecting ack and the given refusal
	task automatic wro(input logic [15:0] i, d, input logic ex);
		ddc_master_model_i.acc(1'b1, i, d, q, a, e);
		chk({14'h0, a, e}, {14'h0, 1'b1, ex});
	endtask : wro

	// Object read with expected data
	task automatic rdo(input logic [15:0] i, x, input logic ex);
		ddc_master_model_i.acc(1'b0, i, 16'h0000, q, a, e);
		chk({14'h0, a, e}, {14'h0, 1'b1, ex});
		chk(q, x);
	endtask : rdo

	// Let the state and status settle, then compare the status word
	task automatic settle(input logic [15:0] x);
		repeat (4) @(posedge clk_sys_i);
		#1 chk(status_o, x);
	endtask : settle

	// Write the command word and check the resulting status
	task automatic cmd(input logic [15:0] w, x);
		wro(16'h6040, w, 1'b0);
		settle(x);
	endtask : cmd

	// Verdict and end of run
	task automatic give_verdict();
		$display("Counts: %0d checks, %0d mismatches", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	// Watchdog against a hang
	initial begin
		repeat (4000) @(posedge clk_sys_i);
		miscompares++;
		give_verdict();
	end

	// Test sequence
	initial begin
		rst_i = 1'b1;
		mode_i = 8'h03;
		{init_done_i, alarm_i, main_power_on_i, motor_stopped_i} = 4'h0;
		{home_err_i, home_ok_i, slip_err_i, speed_flag_i, follow_err_i, set_ack_i, rev_lim_i,
			fwd_lim_i, torque_lim_i, home_done_i, vel_reached_i, pos_reached_i} = 12'h000;
		repeat (10) @(posedge clk_sys_i);
		#1 rst_i = 1'b0;
		chk(status_o, 16'h0000);
		rdo(16'h6040, 16'h0000, 1'b0);
		rdo(16'h605A, 16'h0002, 1'b0);
		rdo(16'h605B, 16'h0000, 1'b0);
		rdo(16'h605C, 16'h0000, 1'b0);
		rdo(16'h6050, 16'h0000, 1'b1);
		wro(16'h6041, 16'h0000, 1'b1);
		wro(16'h605B, 16'h0002, 1'b1);
		$display("test registers done");
		init_done_i = 1'b1;
		settle(16'h0240);
		cmd(16'h000F, 16'h0240);
		cmd(16'hF606, 16'h0221);
		main_power_on_i = 1'b1;
		cmd(16'h0007, 16'h0233);
		chk({14'h0, main_power_o, excite_o}, 16'h0002);
		cmd(16'h000F, 16'h0237);
		chk({15'h0, excite_o}, 16'h0001);
		rdo(16'h6041, 16'h0237, 1'b0);
		cmd(16'h0007, 16'h0233);
		chk({15'h0, excite_o}, 16'h0000);
		$display("test state walk done");
		wro(16'h605B, 16'h0001, 1'b0);
		cmd(16'h000F, 16'h0237);
		cmd(16'h0006, 16'h0237);
		chk({15'h0, decel_o}, 16'h0001);
		motor_stopped_i = 1'b1;
		settle(16'h0231);
		$display("test decelerated shutdown done");
		wro(16'h605A, 16'h0006, 1'b0);
		cmd(16'h0007, 16'h0233);
		cmd(16'h000F, 16'h0237);
		motor_stopped_i = 1'b0;
		cmd(16'h000B, 16'h0217);
		chk({14'h0, decel_o, decel_urgent_o}, 16'h0003);
		cmd(16'h0000, 16'h0250);
		chk({14'h0, main_power_o, excite_o}, 16'h0000);
		$display("test quick stop done");
		main_power_on_i = 1'b0;
		alarm_i = 1'b1;
		settle(16'h0288);
		cmd(16'h0080, 16'h0288);
		alarm_i = 1'b0;
		settle(16'h0240);
		$display("test alarm done");
		mode_i = 8'h01;
		motor_stopped_i = 1'b0;
		wro(16'h605D, 16'h0002, 1'b0);
		cmd(16'h0170, 16'h0240);
		chk({12'h0, new_setpoint_o, change_imm_o, abs_rel_o, halt_o}, 16'h000F);
		chk({15'h0, halt_urgent_o}, 16'h0001);
		motor_stopped_i = 1'b1;
		settle(16'h0640);
		cmd(16'h0000, 16'h0640);
		cmd(16'h0010, 16'h0240);
		mode_i = 8'h06;
		motor_stopped_i = 1'b0;
		settle(16'h0240);
		chk({14'h0, homing_start_o, new_setpoint_o}, 16'h0002);
		for (int k = 0; k < 4; k++) begin
			mode_i = tm[k];
			{home_err_i, home_ok_i, slip_err_i, speed_flag_i, follow_err_i, set_ack_i, rev_lim_i,
				fwd_lim_i, torque_lim_i, home_done_i, vel_reached_i, pos_reached_i} = ts[k];
			settle(te[k]);
		end
		$display("test mode flags done");
		give_verdict();
	end
endmodule : tb_top
